// ### core/rsb_rotate.sv
`timescale 1ns/1ps
`default_nettype none

module rsb_rotate
	import rsb_pkg::*;
(
	input wire rsb_kind_t kind,
	input wire logic [7:0] operand,
	input wire rsb_flags_t flags_in,
	output logic [7:0] result,
	output var rsb_flags_t flags_out
);

	always_comb begin
		result = operand;
		flags_out = flags_in;
		unique case (kind)
			ROT_LEFT_THRU: begin
				result = {operand[6:0], flags_in.c};
				flags_out.c = operand[7];
			end
			ROT_RIGHT: begin
				result = {operand[0], operand[7:1]};
				flags_out.c = operand[0];
			end
			ROT_RIGHT_THRU: begin
				result = {flags_in.c, operand[7:1]};
				flags_out.c = operand[0];
			end
			ROT_BANK_ZERO: begin
				flags_out.bank = 1'b0;
			end
			default: begin
				result = operand;
			end
		endcase
		if (kind == ROT_LEFT_THRU || kind == ROT_RIGHT || kind == ROT_RIGHT_THRU) begin
			flags_out.z = (result == 8'h00);
			flags_out.s = result[7];
			flags_out.v = result[7] ^ operand[7];
		end
	end

endmodule

`default_nettype wire

// ### core/rsb_unit.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - left through carry: carry in, bit7 out
// - opcodes 10/11, two bytes, four cycles
// - plain right: bit0 to bit7 and carry
// - opcodes E0/E1, two bytes, four cycles
// - right through carry: carry in, bit0 out
// - opcodes C0/C1, two bytes, four cycles
// - carry takes the bit shifted out
// - zero on zero result, sign is bit7
// - overflow on sign change; D, H kept
// - opcode 4F clears bank bit only
module rsb_unit
	import rsb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic instr_valid,
	input wire rsb_instr_t instr,
	output logic instr_ready,
	output logic instr_done,
	output logic instr_illegal,
	output logic [1:0] instr_len,
	output var rsb_rf_req_t rf_req,
	input wire logic [7:0] rf_rdata,
	output var rsb_flags_t flags,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_POINT = 2'b10,
		ST_EXEC = 2'b11
	} rsb_state_t;

	rsb_state_t state;
	rsb_kind_t kind_q;
	rsb_kind_t dec_kind;
	logic ind_q;
	logic dec_ind;
	logic [7:0] operand_q;
	logic [7:0] target_q;
	logic [7:0] data_q;
	logic wr_q;
	logic [7:0] waddr_q;
	logic [7:0] wdata_q;
	logic done_q;
	logic illegal_q;
	logic illegal_seen;
	rsb_flags_t flags_q;
	logic [7:0] opnd;
	logic [7:0] rot_result;
	rsb_flags_t rot_flags;
	logic rd_now;
	logic [7:0] rd_addr;
	logic accept;
	logic exec_end;
	logic [7:0] opnd_d;
	rsb_flags_t flags_d;

	always_comb begin
		dec_kind = ROT_NONE;
		dec_ind = 1'b0;
		unique case (instr.opcode)
			OPC_LEFT_THRU_DIR: dec_kind = ROT_LEFT_THRU;
			OPC_LEFT_THRU_IND: begin
				dec_kind = ROT_LEFT_THRU;
				dec_ind = 1'b1;
			end
			OPC_RIGHT_DIR: dec_kind = ROT_RIGHT;
			OPC_RIGHT_IND: begin
				dec_kind = ROT_RIGHT;
				dec_ind = 1'b1;
			end
			OPC_RIGHT_THRU_DIR: dec_kind = ROT_RIGHT_THRU;
			OPC_RIGHT_THRU_IND: begin
				dec_kind = ROT_RIGHT_THRU;
				dec_ind = 1'b1;
			end
			OPC_BANK_ZERO: dec_kind = ROT_BANK_ZERO;
			default: dec_kind = ROT_NONE;
		endcase
	end

	assign instr_ready = (state == ST_IDLE);
	assign accept = instr_valid && instr_ready && (dec_kind != ROT_NONE);
	assign exec_end = (state == ST_EXEC);

	// every instruction spends one cycle in each state
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (accept) begin
						state <= ST_FETCH;
					end
				end
				ST_FETCH: state <= ST_POINT;
				ST_POINT: state <= ST_EXEC;
				ST_EXEC: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			kind_q <= ROT_NONE;
			ind_q <= 1'b0;
			operand_q <= 8'h00;
			instr_len <= 2'h0;
		end else if (accept) begin
			kind_q <= dec_kind;
			ind_q <= dec_ind;
			operand_q <= instr.operand;
			instr_len <= (dec_kind == ROT_BANK_ZERO) ? LEN_BANK : LEN_ROTATE;
		end
	end

	// bank select reads nothing; it only waits out its cycles
	// indirect: pointer read then operand read; direct: operand read only
	always_comb begin
		rd_now = 1'b0;
		rd_addr = operand_q;
		if (state == ST_FETCH) begin
			rd_now = (kind_q != ROT_BANK_ZERO);
		end else if (state == ST_POINT && ind_q) begin
			rd_now = 1'b1;
			rd_addr = rf_rdata;
		end
	end

	// write address wins the shared address lines during the write pulse
	assign rf_req = '{rd: rd_now, wr: wr_q, addr: (wr_q ? waddr_q : rd_addr), wdata: wdata_q};

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			target_q <= 8'h00;
			data_q <= 8'h00;
		end else if (state == ST_POINT) begin
			target_q <= ind_q ? rf_rdata : operand_q;
			data_q <= rf_rdata;
		end
	end

	assign opnd = ind_q ? rf_rdata : data_q;

	rsb_rotate u_rotate (
		.kind(kind_q),
		.operand(opnd),
		.flags_in(flags_q),
		.result(rot_result),
		.flags_out(rot_flags)
	);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 8'h00;
		end else begin
			wr_q <= exec_end && (kind_q != ROT_BANK_ZERO);
			if (exec_end) begin
				waddr_q <= target_q;
				wdata_q <= rot_result;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			done_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			done_q <= exec_end;
			illegal_q <= instr_valid && instr_ready && (dec_kind == ROT_NONE);
		end
	end

	assign instr_done = done_q;
	assign instr_illegal = illegal_q;

	// instruction update beats a software write in the same cycle
	// carry from shifted-out bit
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			flags_q <= FLAGS_RESET;
		end else if (exec_end) begin
			flags_q <= rot_flags;
		end else if (reg_wr && reg_addr == REG_FLAGS) begin
			flags_q <= reg_wdata;
		end
	end

	assign flags = flags_q;

	// sticky illegal flag, set wins over a write-one clear
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			illegal_seen <= 1'b0;
		end else if (instr_valid && instr_ready && dec_kind == ROT_NONE) begin
			illegal_seen <= 1'b1;
		end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_ILLEGAL]) begin
			illegal_seen <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_FLAGS: reg_rdata <= flags_q;
				REG_STATUS: begin
					reg_rdata <= 8'h00;
					reg_rdata[ST_BUSY] <= (state != ST_IDLE);
					reg_rdata[ST_INDIRECT] <= ind_q;
					reg_rdata[ST_ILLEGAL] <= illegal_seen;
				end
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// helper state for the checks below
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			opnd_d <= 8'h00;
			flags_d <= FLAGS_RESET;
		end else if (exec_end) begin
			opnd_d <= opnd;
			flags_d <= flags_q;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	left_thru_a: assert property (
		done_q && kind_q == ROT_LEFT_THRU |->
			wdata_q == {opnd_d[6:0], flags_d.c} && flags_q.c == opnd_d[7])
		else $error("left rotate through carry wrong");

	// a new request may be taken in the done cycle itself
	instr_span_a: assert property (
		accept |=> !instr_done [*3] ##1 instr_done && instr_ready)
		else $error("instruction did not take four cycles");

	span_busy_a: assert property (
		accept |=> !instr_ready [*3] ##1 instr_ready)
		else $error("ready not low for three cycles");

	left_dir_decode_a: assert property (
		instr_valid && instr_ready && instr.opcode == OPC_LEFT_THRU_DIR |=>
			kind_q == ROT_LEFT_THRU && !ind_q && instr_len == LEN_ROTATE)
		else $error("left rotate direct decode wrong");

	left_ind_decode_a: assert property (
		instr_valid && instr_ready && instr.opcode == OPC_LEFT_THRU_IND |=>
			kind_q == ROT_LEFT_THRU && ind_q && instr_len == LEN_ROTATE)
		else $error("left rotate indirect decode wrong");

	direct_target_a: assert property (
		state == ST_FETCH && !ind_q && kind_q != ROT_BANK_ZERO |->
			rf_req.rd && rf_req.addr == operand_q ##3 wr_q && rf_req.addr == $past(operand_q, 3))
		else $error("direct operand address wrong");

	right_decode_a: assert property (
		instr_valid && instr_ready && instr.opcode == OPC_RIGHT_IND |=>
			kind_q == ROT_RIGHT && ind_q && instr_len == LEN_ROTATE)
		else $error("rotate right decode wrong");

	right_dir_decode_a: assert property (
		instr_valid && instr_ready && instr.opcode == OPC_RIGHT_DIR |=>
			kind_q == ROT_RIGHT && !ind_q && instr_len == LEN_ROTATE)
		else $error("rotate right direct decode wrong");

	right_shift_a: assert property (
		done_q && kind_q == ROT_RIGHT |-> wdata_q == {opnd_d[0], opnd_d[7:1]})
		else $error("plain right rotate wrong");

	right_thru_a: assert property (
		done_q && kind_q == ROT_RIGHT_THRU |-> wdata_q == {flags_d.c, opnd_d[7:1]})
		else $error("right rotate through carry wrong");

	thru_decode_a: assert property (
		instr_valid && instr_ready && instr.opcode == OPC_RIGHT_THRU_DIR |=>
			kind_q == ROT_RIGHT_THRU && !ind_q ##3 instr_done)
		else $error("rotate right through carry decode wrong");

	thru_ind_decode_a: assert property (
		instr_valid && instr_ready && instr.opcode == OPC_RIGHT_THRU_IND |=>
			kind_q == ROT_RIGHT_THRU && ind_q && instr_len == LEN_ROTATE ##3 instr_done)
		else $error("rotate right through carry indirect decode wrong");

	right_carry_a: assert property (
		done_q && (kind_q == ROT_RIGHT || kind_q == ROT_RIGHT_THRU) |-> flags_q.c == opnd_d[0])
		else $error("carry not from bit 0");

	zero_sign_a: assert property (
		done_q && kind_q != ROT_BANK_ZERO |->
			flags_q.z == (wdata_q == 8'h00) && flags_q.s == wdata_q[7] && wr_q)
		else $error("zero or sign flag wrong");

	overflow_kept_a: assert property (
		done_q && kind_q != ROT_BANK_ZERO |-> flags_q.v == (wdata_q[7] ^ opnd_d[7])
			&& flags_q.d == flags_d.d && flags_q.h == flags_d.h)
		else $error("overflow or kept flags wrong");

	rot_keeps_bank_a: assert property (
		done_q && kind_q != ROT_BANK_ZERO |->
			flags_q.bank == flags_d.bank && flags_q.fu == flags_d.fu)
		else $error("rotate touched bank or spare flag");

	bank_zero_a: assert property (
		done_q && kind_q == ROT_BANK_ZERO |->
			!flags_q.bank && !wr_q && flags_q[7:1] == flags_d[7:1] && instr_len == LEN_BANK)
		else $error("bank select wrong");

	bank_decode_a: assert property (
		instr_valid && instr_ready && instr.opcode == OPC_BANK_ZERO |=>
			kind_q == ROT_BANK_ZERO && instr_len == LEN_BANK ##3 instr_done)
		else $error("bank select decode wrong");

	// bank select must leave the register file alone
	bank_quiet_a: assert property (
		kind_q == ROT_BANK_ZERO && !instr_ready |-> !rf_req.rd && !rf_req.wr)
		else $error("bank select touched register file");

	direct_no_ptr_a: assert property (
		state == ST_POINT && !ind_q |-> !rf_req.rd)
		else $error("direct mode made a pointer read");

	single_write_a: assert property (
		wr_q |=> !wr_q)
		else $error("more than one write per instruction");

	pointer_use_a: assert property (
		state == ST_POINT && ind_q |-> rf_req.rd && rf_req.addr == rf_rdata
			##2 wr_q && rf_req.addr == $past(rf_rdata, 2))
		else $error("indirect target wrong");

endmodule

`default_nettype wire

// ### shared/rsb_pkg.sv
`default_nettype none

package rsb_pkg;

	// opcodes
	localparam logic [7:0] OPC_LEFT_THRU_DIR = 8'h10;
	localparam logic [7:0] OPC_LEFT_THRU_IND = 8'h11;
	localparam logic [7:0] OPC_RIGHT_DIR = 8'he0;
	localparam logic [7:0] OPC_RIGHT_IND = 8'he1;
	localparam logic [7:0] OPC_RIGHT_THRU_DIR = 8'hc0;
	localparam logic [7:0] OPC_RIGHT_THRU_IND = 8'hc1;
	localparam logic [7:0] OPC_BANK_ZERO = 8'h4f;

	// instruction lengths in bytes and cycles
	localparam logic [1:0] LEN_ROTATE = 2'h2;
	localparam logic [1:0] LEN_BANK = 2'h1;
	localparam int unsigned INSTR_CYCLES = 4;

	// software register offsets
	localparam logic [3:0] REG_FLAGS = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;

	// status register bit positions
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_INDIRECT = 1;
	localparam int unsigned ST_ILLEGAL = 2;

	// reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	typedef enum logic [2:0] {
		ROT_NONE = 3'b000,
		ROT_LEFT_THRU = 3'b001,
		ROT_RIGHT = 3'b010,
		ROT_RIGHT_THRU = 3'b011,
		ROT_BANK_ZERO = 3'b100
	} rsb_kind_t;

	// bit 7 down to bit 0 of the flags register
	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
		logic fu;
		logic bank;
	} rsb_flags_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] operand;
	} rsb_instr_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsb_rf_req_t;

endpackage

`default_nettype wire

// ### tb/rsb_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module rsb_unit_tb_top import rsb_pkg::*;;
	localparam logic [7:0] ops [6] = '{8'h10, 8'h11, 8'he0, 8'he1, 8'hc0, 8'hc1};
	localparam logic [7:0] vals [6] = '{8'haa, 8'h80, 8'h31, 8'h00, 8'h55, 8'h01};
	localparam logic [7:0] fins [6] = '{8'h00, 8'h0e, 8'h05, 8'h80, 8'h80, 8'h01};
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic instr_valid = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	rsb_instr_t instr = '0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] rf_rdata = 8'h00;
	logic instr_ready;
	logic instr_done;
	logic instr_illegal;
	logic [1:0] instr_len;
	rsb_rf_req_t rf_req;
	rsb_flags_t flags;
	logic [7:0] reg_rdata;
	logic [7:0] mem [256];
	logic [7:0] last_wa = 8'h00;
	int wr_cnt = 0;
	int err_total = 0;
	int num_checks = 0;

	rsb_unit dut (
		.clk_sys(clk_sys),
		.reset(reset),
		.instr_valid(instr_valid),
		.instr(instr),
		.instr_ready(instr_ready),
		.instr_done(instr_done),
		.instr_illegal(instr_illegal),
		.instr_len(instr_len),
		.rf_req(rf_req),
		.rf_rdata(rf_rdata),
		.flags(flags),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);

	always #50 clk_sys = ~clk_sys;

	// register file; idle read data toggles so stale values never match
	always @(posedge clk_sys) begin
		if (rf_req.rd)
			rf_rdata <= mem[rf_req.addr];
		else
			rf_rdata <= ~rf_rdata;
		if (rf_req.wr) begin
			mem[rf_req.addr] <= rf_req.wdata;
			last_wa <= rf_req.addr;
			wr_cnt <= wr_cnt + 1;
		end
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk1(input string name, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// expected result and flags, bank and d/h/fu kept
	function automatic logic [15:0] model(input logic [7:0] op, input logic [7:0] a,
		input logic [7:0] f);
		logic [7:0] r;
		logic c;
		r = {a[0], a[7:1]};
		c = a[0];
		if (op[7:4] == 4'h1) begin
			r = {a[6:0], f[7]};
			c = a[7];
		end
		if (op[7:4] == 4'hc)
			r[7] = f[7];
		return {r, c, r == 8'h00, r[7], r[7] ^ a[7], f[3:0]};
	endfunction

	task automatic run(input logic [7:0] op, input logic [7:0] opnd, input logic [7:0] tgt,
		input logic [7:0] exp_r, input logic [7:0] exp_f);
		int w0;
		logic rot;
		rot = (op != OPC_BANK_ZERO);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr <= {op, opnd};
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		w0 = wr_cnt;
		repeat (2) @(posedge clk_sys);
		#1;
		chk1("done early", 1'b0, instr_done);
		chk1("ready busy", 1'b0, instr_ready);
		@(posedge clk_sys);
		#1;
		chk1("done", 1'b1, instr_done);
		chk8("flags", exp_f, flags);
		chk8("length", {6'h0, rot ? LEN_ROTATE : LEN_BANK}, {6'h0, instr_len});
		@(posedge clk_sys);
		#1;
		chk8("writes", {7'h0, rot}, 8'(wr_cnt - w0));
		if (rot)
			chk8("result", exp_r, mem[tgt]);
		if (rot)
			chk8("write addr", tgt, last_wa);
	endtask

	initial begin
		#300000;
		err_total++;
		end_of_test();
	end

	initial begin
		logic [7:0] d;
		logic [15:0] e;
		logic [7:0] opnd;
		logic [7:0] tgt;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		chk8("flags reset", FLAGS_RESET, flags);
		chk1("ready reset", 1'b1, instr_ready);
		chk8("rdata reset", 8'h00, reg_rdata);
		for (int i = 0; i < 6; i++) begin
			opnd = 8'h30 + 8'(i);
			tgt = opnd;
			if (ops[i][0]) begin
				tgt = 8'h40 + 8'(i);
				mem[opnd] = tgt;
			end
			mem[tgt] = vals[i];
			reg_write(REG_FLAGS, fins[i]);
			reg_read(REG_FLAGS, d);
			chk8("flags rw", fins[i], d);
			e = model(ops[i], vals[i], fins[i]);
			// status read lands in the execute cycle: busy and mode visible
			fork
				run(ops[i], opnd, tgt, e[15:8], e[7:0]);
				begin
					repeat (3) @(posedge clk_sys);
					reg_read(REG_STATUS, d);
				end
			join
			chk8("status busy", {6'h0, ops[i][0], 1'b1}, d);
			if (ops[i][0])
				chk8("pointer", tgt, mem[opnd]);
		end
		reg_write(REG_FLAGS, 8'hff);
		run(OPC_BANK_ZERO, 8'h00, 8'h00, 8'h00, 8'hfe);
		// held request: second bank select taken in the done cycle
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr <= {OPC_BANK_ZERO, 8'h00};
		repeat (5) @(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
		chk1("back to back", 1'b0, instr_ready);
		repeat (3) @(posedge clk_sys);
		#1;
		chk1("second done", 1'b1, instr_done);
		chk8("flags b2b", 8'hfe, flags);
		// unknown opcode is refused, flagged, and the sticky bit clears on write
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr <= {8'h90, 8'h00};
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
		chk1("illegal", 1'b1, instr_illegal);
		reg_read(REG_STATUS, d);
		chk1("illegal drop", 1'b0, instr_illegal);
		chk8("status", 8'h04, d);
		reg_write(REG_STATUS, 8'h04);
		reg_read(REG_STATUS, d);
		chk1("sticky clear", 1'b0, d[ST_ILLEGAL]);
		reg_read(4'hf, d);
		chk8("unmapped", 8'h00, d);
		end_of_test();
	end
endmodule

`default_nettype wire
